/* File: rtl/ctm_pkg.sv */
// Package: register map, field codes and reset values of the compact timer core
package ctm_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_PIN_SELECT = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_0  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_1  = 8'h08;
  localparam logic [7:0] ADDR_CNT_LOW    = 8'h0C;
  localparam logic [7:0] ADDR_CNT_HIGH   = 8'h10;
  localparam logic [7:0] ADDR_CMPA_LOW   = 8'h14;
  localparam logic [7:0] ADDR_CMPA_HIGH  = 8'h18;
  localparam logic [7:0] ADDR_PERIOD     = 8'h1C;

  // Reset values
  localparam logic [4:0]  RST_PIN_SELECT = 5'h00;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;

  // Clock select codes
  localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CK_SYS       = 3'h1;
  localparam logic [2:0] CK_HIGH_D16  = 3'h2;
  localparam logic [2:0] CK_HIGH_D64  = 3'h3;
  localparam logic [2:0] CK_SUB       = 3'h4;
  localparam logic [2:0] CK_RESERVED  = 3'h5;
  localparam logic [2:0] CK_EXT_RISE  = 3'h6;
  localparam logic [2:0] CK_EXT_FALL  = 3'h7;

  // Prescaler terminal counts
  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  // Output action codes
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Mode encodings follow declaration order: 00, 01, 10, 11
  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_UNDEFINED,
    MODE_PWM,
    MODE_TIMER
  } ctm_mode_t;

  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select;
    logic       run_enable;
  } ctm_ctrl0_t;

  typedef struct packed {
    ctm_mode_t  mode_select;
    logic [1:0] output_action;
    logic       output_initial_level;
    logic       output_polarity;
    logic       period_duty_swap;
    logic       clear_select;
  } ctm_ctrl1_t;

  typedef struct packed {
    logic period;
    logic compare_a;
  } ctm_irq_t;

endpackage

/* File: rtl/ctm_core.sv */
// Compact 16-bit timer core with APB register slave and pin routing
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

module ctm_core
(
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ctm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       external_clock_input,
  input  wire logic                       sub_clock_in,
  input  wire logic                       shared_out_0,
  output logic                            timer_output_0,
  output logic      [4:0]                 pin_route,
  output ctm_pkg::ctm_irq_t               irq
);
  import ctm_pkg::*;

  logic [4:0]  pin_sel;
  ctm_ctrl0_t  ctrl0;
  ctm_ctrl1_t  ctrl1;
  logic [15:0] cnt;
  logic [15:0] cmpa;
  logic [7:0]  period;
  logic [7:0]  hold_buf;
  logic        run_q;
  logic        tout;
  logic [5:0]  prescale;

  // Asynchronous pins: two stages before any use, a third for edges
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_s3;
  logic        sub_s1;
  logic        sub_s2;
  logic        sub_s3;

  wire         setup_rd   = psel & ~penable & ~pwrite;
  wire         setup_any  = psel & ~penable;
  wire         access     = psel & penable;
  wire         wr         = access & pwrite;
  wire         rd         = access & ~pwrite;
  wire [7:0]   addr       = paddr;
  wire [7:0]   wbyte      = pwdata[7:0];

  wire         sel_pin    = (addr == ADDR_PIN_SELECT);
  wire         sel_c0     = (addr == ADDR_CONTROL_0);
  wire         sel_c1     = (addr == ADDR_CONTROL_1);
  wire         sel_cnt_lo = (addr == ADDR_CNT_LOW);
  wire         sel_cnt_hi = (addr == ADDR_CNT_HIGH);
  wire         sel_a_lo   = (addr == ADDR_CMPA_LOW);
  wire         sel_a_hi   = (addr == ADDR_CMPA_HIGH);
  wire         sel_per    = (addr == ADDR_PERIOD);
  wire         mapped     = sel_pin | sel_c0 | sel_c1 | sel_cnt_lo | sel_cnt_hi
                          | sel_a_lo | sel_a_hi | sel_per;

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;

  wire [7:0]   rd_byte =
      sel_pin    ? {3'h0, pin_sel} :
      sel_c0     ? {ctrl0, 3'h0} :
      sel_c1     ? ctrl1 :
      sel_cnt_hi ? cnt[15:8] :
      sel_a_hi   ? cmpa[15:8] :
      sel_per    ? period :
      (sel_cnt_lo | sel_a_lo) ? hold_buf :
      8'h00;

  // Prescaled and external tick sources
  wire         ext_rise = ext_s2 & ~ext_s3;
  wire         ext_fall = ~ext_s2 & ext_s3;
  wire         sub_rise = sub_s2 & ~sub_s3;

  logic        tick;
  always_comb
  begin
    case (ctrl0.clock_select)
      CK_SYS_DIV4: tick = ((prescale & DIV4_MASK) == DIV4_MASK);
      CK_SYS:      tick = 1'b1;
      CK_HIGH_D16: tick = ((prescale & DIV16_MASK) == DIV16_MASK);
      CK_HIGH_D64: tick = ((prescale & DIV64_MASK) == DIV64_MASK);
      CK_SUB:      tick = sub_rise;
      CK_EXT_RISE: tick = ext_rise;
      CK_EXT_FALL: tick = ext_fall;
      default:     tick = 1'b0;
    endcase
  end

  wire         run_edge  = ctrl0.run_enable & ~run_q;
  wire         count_en  = tick & ctrl0.run_enable & ~ctrl0.pause_bit;
  wire         is_pwm    = (ctrl1.mode_select == MODE_PWM);
  wire         is_timer  = (ctrl1.mode_select == MODE_TIMER);
  wire         is_cmp    = (ctrl1.mode_select == MODE_COMPARE);

  // Period hit on the last count of 256*P; P of zero means full wrap
  wire [7:0]   per_m1    = 8'(period - 8'h01);
  wire         p_match   = count_en & (cnt[15:8] == per_m1)
                         & (cnt[7:0] == 8'hFF);
  wire         a_match   = count_en & (cnt == cmpa);
  wire         clr_on_a  = is_pwm ? ctrl1.period_duty_swap
                                  : ctrl1.clear_select;
  wire         auto_clr  = clr_on_a ? a_match : p_match;

  logic [15:0] next_cnt;
  always_comb
  begin
    if (run_edge)
      next_cnt = RST_WORD;
    else if (auto_clr)
      next_cnt = RST_WORD;
    else if (count_en)
      next_cnt = 16'(cnt + 16'h0001);
    else
      next_cnt = cnt;
  end

  // PWM duty reference depends on the period/duty swap
  wire [15:0]  duty      = ctrl1.period_duty_swap ? {period, 8'h00} : cmpa;
  wire         act_lvl   = ctrl1.output_initial_level;
  wire         pwm_lvl   =
      (ctrl1.output_action == ACT_LOW)  ? act_lvl :
      (ctrl1.output_action == ACT_HIGH) ? ((cnt < duty) ? act_lvl : ~act_lvl) :
      ~act_lvl;

  wire         raw_out   = is_pwm ? pwm_lvl : tout;
  wire         final_out = is_timer ? 1'b0 : (raw_out ^ ctrl1.output_polarity);

  logic        next_tout;
  always_comb
  begin
    next_tout = tout;
    if (run_edge)
      next_tout = act_lvl;
    else if (is_cmp & a_match)
    begin
      case (ctrl1.output_action)
        ACT_LOW:    next_tout = 1'b0;
        ACT_HIGH:   next_tout = 1'b1;
        ACT_TOGGLE: next_tout = ~tout;
        default:    next_tout = tout;
      endcase
    end
  end

  // Synchronisers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end
    else
    begin
      ext_s1 <= external_clock_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      sub_s1 <= sub_clock_in;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // Counter, prescaler and output state
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt      <= RST_WORD;
      run_q    <= 1'b0;
      tout     <= 1'b0;
      prescale <= 6'h00;
      irq      <= '0;
    end
    else
    begin
      cnt           <= next_cnt;
      run_q         <= ctrl0.run_enable;
      tout          <= next_tout;
      prescale      <= 6'(prescale + 6'h01);
      irq.period    <= p_match;
      irq.compare_a <= a_match;
    end
  end

  // Pin mux: one timer output, enables exported for the other pins
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      timer_output_0 <= 1'b0;
    else
      timer_output_0 <= pin_sel[0] ? final_out : shared_out_0;
  end

  assign pin_route = pin_sel;

  // Register writes and buffer transfers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_sel  <= RST_PIN_SELECT;
      ctrl0    <= '0;
      ctrl1    <= '0;
      cmpa     <= RST_WORD;
      period   <= RST_BYTE;
      hold_buf <= RST_BYTE;
    end
    else
    begin
      if (wr & sel_pin)
        pin_sel <= wbyte[4:0];
      if (wr & sel_c0)
        ctrl0 <= wbyte[7:3];
      if (wr & sel_c1)
        ctrl1 <= wbyte;
      if (wr & sel_per)
        period <= wbyte;
      // Low byte latched with the high read data: one snapshot of the pair
      if (wr & sel_a_lo)
        hold_buf <= wbyte;
      else if (setup_rd & sel_cnt_hi)
        hold_buf <= cnt[7:0];
      else if (setup_rd & sel_a_hi)
        hold_buf <= cmpa[7:0];
      if (wr & sel_a_hi)
        cmpa <= {wbyte, hold_buf};
    end
  end

  // Read data and error captured in setup, presented in access
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_any)
    begin
      prdata  <= setup_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= ~mapped;
    end
  end

  sequence s_write(logic hit);
    psel & penable & pwrite & hit;
  endsequence

  sequence s_read(logic hit);
    rd & hit;
  endsequence

  // Read data and buffer are both taken at the setup edge
  sequence s_setup_read(logic hit);
    setup_rd & hit;
  endsequence

  a_run_rise_clear: assert property (@(posedge mclk) disable iff (!nrst)
    run_edge |=> cnt == 16'h0000)
    else $error("counter not cleared on run rising");

  a_pause_freeze: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl0.pause_bit & run_q & ctrl0.run_enable |=> $stable(cnt))
    else $error("counter moved while paused");

  a_reserved_halt: assert property (@(posedge mclk) disable iff (!nrst)
    ctrl0.clock_select == CK_RESERVED && !run_edge |=> $stable(cnt))
    else $error("counter moved on reserved clock");

  a_count_step: assert property (@(posedge mclk) disable iff (!nrst)
    count_en & ~auto_clr & ~run_edge |=> cnt == 16'($past(cnt) + 16'h0001))
    else $error("counter did not step by one");

  a_match_clear: assert property (@(posedge mclk) disable iff (!nrst)
    a_match & clr_on_a & ~run_edge |=> cnt == 16'h0000 ##1 !irq.period)
    else $error("compare-A match did not clear counter");

  a_period_request: assert property (@(posedge mclk) disable iff (!nrst)
    p_match |=> irq.period ##1 cnt != 16'h0000 || !count_en)
    else $error("period match request missing");

  a_low_write_buf: assert property (@(posedge mclk) disable iff (!nrst)
    s_write(sel_a_lo) |=> hold_buf == $past(pwdata[7:0]) && $stable(cmpa))
    else $error("compare low write reached compare register");

  a_high_write_pair: assert property (@(posedge mclk) disable iff (!nrst)
    s_write(sel_a_hi) |=> cmpa == {$past(pwdata[7:0]), $past(hold_buf)})
    else $error("compare high write did not load pair");

  a_high_read_latch: assert property (@(posedge mclk) disable iff (!nrst)
    s_read(sel_cnt_hi) |-> hold_buf == $past(cnt[7:0]))
    else $error("counter high read did not latch low byte");

  a_pin_route: assert property (@(posedge mclk) disable iff (!nrst)
    !pin_sel[0] |=> timer_output_0 == $past(shared_out_0))
    else $error("disabled pin not left to shared function");

  a_pin_enable_out: assert property (@(posedge mclk) disable iff (!nrst)
    pin_sel[0] |=> timer_output_0 == $past(final_out))
    else $error("enabled pin not driven by timer");

  a_pin_read_zero: assert property (@(posedge mclk) disable iff (!nrst)
    s_setup_read(sel_pin) |=> prdata == {27'h000_0000, $past(pin_sel)})
    else $error("pin select read back wrong");

  a_high_read_cnt: assert property (@(posedge mclk) disable iff (!nrst)
    s_setup_read(sel_cnt_hi) |=> prdata == {24'h00_0000, $past(cnt[15:8])})
    else $error("counter high byte read wrong");

  a_low_read_buf: assert property (@(posedge mclk) disable iff (!nrst)
    s_setup_read(sel_cnt_lo | sel_a_lo) |=> prdata == {24'h00_0000, $past(hold_buf)})
    else $error("low byte read not from buffer");

  a_cmpa_high_latch: assert property (@(posedge mclk) disable iff (!nrst)
    s_setup_read(sel_a_hi) |=> hold_buf == $past(cmpa[7:0]))
    else $error("compare high read did not latch low byte");

  a_run_init_level: assert property (@(posedge mclk) disable iff (!nrst)
    run_edge |=> tout == $past(act_lvl))
    else $error("output not set to initial level on run");

  a_cmp_toggle: assert property (@(posedge mclk) disable iff (!nrst)
    is_cmp & a_match & ~run_edge & (ctrl1.output_action == ACT_TOGGLE)
    |=> tout != $past(tout))
    else $error("compare match did not toggle output");

  a_timer_mode_out: assert property (@(posedge mclk) disable iff (!nrst)
    is_timer & pin_sel[0] |=> !timer_output_0)
    else $error("timer mode drove the output pin");

  a_pwm_active: assert property (@(posedge mclk) disable iff (!nrst)
    is_pwm & pin_sel[0] & ~ctrl1.output_polarity & (ctrl1.output_action == ACT_HIGH)
    & (cnt < duty) |=> timer_output_0 == $past(act_lvl))
    else $error("pwm output not active below duty");

  a_match_request: assert property (@(posedge mclk) disable iff (!nrst)
    a_match |=> irq.compare_a)
    else $error("compare-A request missing");

  a_period_clear: assert property (@(posedge mclk) disable iff (!nrst)
    p_match & ~clr_on_a & ~run_edge |=> cnt == 16'h0000)
    else $error("period match did not clear counter");

endmodule // ctm_core

/* File: tb/tb.sv */
// Self-checking testbench for the compact timer core
`timescale 1ns/1ps

module tb;
  import ctm_pkg::*;

  logic              mclk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ext_clk;
  logic              sub_clk;
  logic              shared_out_0;
  logic              timer_output_0;
  logic [4:0]        pin_route;
  ctm_irq_t          irq;
  int                n_mismatch;
  int                n_compared;

  ctm_core u_ctm_core
  (
    .mclk                 (mclk),
    .nrst                 (nrst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .external_clock_input (ext_clk),
    .sub_clock_in         (sub_clk),
    .shared_out_0         (shared_out_0),
    .timer_output_0       (timer_output_0),
    .pin_route            (pin_route),
    .irq                  (irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 8'h00, r, e);
    check(r, {24'h00_0000, exp});
    check({31'h0000_0000, e}, 32'h0000_0000);
  endtask

  task automatic wait_irq(input logic sel, input int lim);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (!seen && n < lim)
    begin
      @(posedge mclk);
      #1;
      seen = ((sel ? irq.compare_a : irq.period) === 1'b1);
      n++;
    end
    check({31'h0000_0000, seen}, 32'h0000_0001);
    @(posedge mclk);
    #1;
    check({31'h0000_0000, sel ? irq.compare_a : irq.period}, 32'h0000_0000);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), 8'h00);
    wr(8'h20, 8'hFF);
    apb(8'h20, 1'b0, 8'h00, r, e);
    check(r, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
  endtask

  task automatic t_pins();
    wr(ADDR_PIN_SELECT, 8'hFF);
    rdc(ADDR_PIN_SELECT, 8'h1F);
    check({27'h000_0000, pin_route}, 32'h0000_001F);
    wr(ADDR_PIN_SELECT, 8'h00);
    shared_out_0 <= 1'b1;
    repeat (3) @(posedge mclk);
    check({31'h0000_0000, timer_output_0}, 32'h0000_0001);
    wr(ADDR_PIN_SELECT, 8'h01);
    repeat (3) @(posedge mclk);
    check({31'h0000_0000, timer_output_0}, 32'h0000_0000);
  endtask

  task automatic t_cmpa_pair();
    wr(ADDR_CMPA_LOW, 8'h34);
    wr(ADDR_CMPA_HIGH, 8'h12);
    rdc(ADDR_CMPA_HIGH, 8'h12);
    rdc(ADDR_CMPA_LOW, 8'h34);
    wr(ADDR_CMPA_LOW, 8'h56);
    rdc(ADDR_CMPA_HIGH, 8'h12);
    rdc(ADDR_CMPA_LOW, 8'h34);
  endtask

  task automatic t_ext_count();
    wr(ADDR_CONTROL_1, 8'hC0);
    wr(ADDR_PERIOD, 8'h00);
    wr(ADDR_CONTROL_0, 8'h60);
    wr(ADDR_CONTROL_0, 8'h68);
    repeat (5)
    begin
      @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h05);
    wr(ADDR_CNT_HIGH, 8'hAA);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h05);
    wr(ADDR_CONTROL_0, 8'h60);
    wr(ADDR_CONTROL_0, 8'h68);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h00);
  endtask

  // Reserved code selected while running: no run edge, count must hold at 3
  task automatic t_reserved();
    wr(ADDR_CONTROL_0, 8'h18);
    wr(ADDR_CONTROL_0, 8'h58);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h03);
    repeat (20) @(posedge mclk);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h03);
  endtask

  task automatic t_period_pause();
    logic [31:0] h1;
    logic [31:0] l1;
    logic [31:0] h2;
    logic [31:0] l2;
    logic        e;
    wr(ADDR_CONTROL_0, 8'h10);
    wr(ADDR_PERIOD, 8'h01);
    wr(ADDR_CONTROL_0, 8'h18);
    wait_irq(1'b0, 600);
    wr(ADDR_CONTROL_0, 8'h98);
    apb(ADDR_CNT_HIGH, 1'b0, 8'h00, h1, e);
    apb(ADDR_CNT_LOW, 1'b0, 8'h00, l1, e);
    repeat (10) @(posedge mclk);
    apb(ADDR_CNT_HIGH, 1'b0, 8'h00, h2, e);
    apb(ADDR_CNT_LOW, 1'b0, 8'h00, l2, e);
    check({h2[15:0], l2[15:0]}, {h1[15:0], l1[15:0]});
    wr(ADDR_CONTROL_0, 8'h18);
    repeat (10) @(posedge mclk);
    wr(ADDR_CONTROL_0, 8'h98);
    apb(ADDR_CNT_HIGH, 1'b0, 8'h00, h2, e);
    apb(ADDR_CNT_LOW, 1'b0, 8'h00, l2, e);
    check(32'({h2[7:0], l2[7:0]} > {h1[7:0], l1[7:0]}), 32'h0000_0001);
  endtask

  // Second pulse within the bound only if the match really cleared
  task automatic t_cmpa_clear();
    wr(ADDR_CONTROL_0, 8'h10);
    wr(ADDR_CMPA_LOW, 8'h20);
    wr(ADDR_CMPA_HIGH, 8'h00);
    wr(ADDR_CONTROL_1, 8'hC1);
    wr(ADDR_CONTROL_0, 8'h18);
    wait_irq(1'b1, 100);
    wait_irq(1'b1, 60);
    check({31'h0000_0000, irq.period}, 32'h0000_0000);
  endtask

  task automatic t_modes();
    wr(ADDR_CONTROL_0, 8'h10);
    wr(ADDR_CONTROL_1, 8'h31);
    wr(ADDR_CONTROL_0, 8'h18);
    wait_irq(1'b1, 100);
    check({31'h0000_0000, timer_output_0}, 32'h0000_0001);
    wr(ADDR_CONTROL_1, 8'hF1);
    repeat (2) @(posedge mclk);
    #1;
    check({31'h0000_0000, timer_output_0}, 32'h0000_0000);
    wr(ADDR_CONTROL_0, 8'h10);
    wr(ADDR_CONTROL_1, 8'hA8);
    wr(ADDR_CONTROL_0, 8'h18);
    repeat (5) @(posedge mclk);
    #1;
    check({31'h0000_0000, timer_output_0}, 32'h0000_0001);
    repeat (40) @(posedge mclk);
    #1;
    check({31'h0000_0000, timer_output_0}, 32'h0000_0000);
  endtask

  task automatic pulses(input logic on_sub, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      if (on_sub)
        sub_clk <= 1'b1;
      else
        ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      sub_clk <= 1'b0;
      ext_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
  endtask

  // Divide-by-4 phase is free running, so 43 cycles give 10 or 11 ticks
  task automatic t_clocks();
    logic [31:0] r;
    logic        e;
    wr(ADDR_CONTROL_0, 8'h00);
    wr(ADDR_CONTROL_0, 8'h08);
    repeat (40) @(posedge mclk);
    wr(ADDR_CONTROL_0, 8'h88);
    rdc(ADDR_CNT_HIGH, 8'h00);
    apb(ADDR_CNT_LOW, 1'b0, 8'h00, r, e);
    check(32'(r == 32'h0000_000A || r == 32'h0000_000B), 32'h0000_0001);
    wr(ADDR_CONTROL_0, 8'h70);
    wr(ADDR_CONTROL_0, 8'h78);
    pulses(1'b0, 3);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h03);
    wr(ADDR_CONTROL_0, 8'h40);
    wr(ADDR_CONTROL_0, 8'h48);
    pulses(1'b1, 2);
    rdc(ADDR_CNT_HIGH, 8'h00);
    rdc(ADDR_CNT_LOW, 8'h02);
  endtask

  initial
  begin
    n_mismatch   = 0;
    n_compared   = 0;
    nrst         = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0000_0000;
    ext_clk      = 1'b0;
    sub_clk      = 1'b0;
    shared_out_0 = 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_pins();
    t_cmpa_pair();
    t_ext_count();
    t_reserved();
    t_period_pause();
    t_cmpa_clear();
    t_modes();
    t_clocks();
    give_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule // tb
